// *** cdi_dev.sv ***
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`include "cdi_map.svh"
module cdi_dev
  import cdi_pkg::*;
#(
  parameter int SEG_COUNT = `CDI_SEG_COUNT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command link
  cdi_link_if.dev link,
  // device context
  input wire logic [1:0] polarity_mode_field_i,
  input wire logic [4:0] first_param_index_i,
  input wire logic update_busy_i,
  input wire logic update_done_i,
  input wire logic [SEG_COUNT-1:0] next_segment_image_i,
  input wire logic next_backplane_bit_i,
  // stored image
  output logic [SEG_COUNT-1:0] current_segment_image_o,
  output logic current_backplane_bit_o
);
  // last byte slot of the image; bytes past it are not stored
  localparam logic [4:0] LAST_INDEX = 5'(SEG_COUNT / 8 - 1);

  // whole state in one word; only the control part sees reset
  typedef struct packed {
    cdi_dev_state_t state;
    logic [7:0] cmd;
    logic [4:0] index;
    logic drop;
    logic [SEG_COUNT-1:0] seg;
    logic bp;
  } cdi_dev_st_t;

  cdi_dev_st_t st;
  cdi_dev_st_t next_st;
  logic cmd_in;
  logic byte_in;
  logic accept;
  logic [7:0] stored_byte;

  // odd polarity codes invert, even ones store as written
  function automatic logic [7:0] apply_polarity(
    input logic [1:0] mode,
    input logic [7:0] value
  );
    logic [7:0] result;
    if (mode[`CDI_POL_INV_BIT]) begin
      result = ~value;
    end else begin
      result = value;
    end
    return result;
  endfunction

  function automatic logic is_load_cmd(input logic [7:0] code);
    logic result;
    result = (code == `CDI_CMD_LOAD_SEGMENTS) || (code == `CDI_CMD_LOAD_BACKPLANE);
    return result;
  endfunction

  function automatic logic [SEG_COUNT-1:0] place_byte(
    input logic [SEG_COUNT-1:0] image,
    input logic [4:0] index,
    input logic [7:0] value
  );
    logic [SEG_COUNT-1:0] result;
    result = image;
    result[{index, 3'h0} +: 8] = value;
    return result;
  endfunction

  assign link.ready = 1'b1;
  assign cmd_in = link.valid && link.is_cmd;
  assign byte_in = link.valid && !link.is_cmd;
  assign stored_byte = apply_polarity(polarity_mode_field_i, link.data);
  // a byte lands only outside an update, for a command taken outside one
  assign accept = byte_in && !update_busy_i && !st.drop;
  assign current_segment_image_o = st.seg;
  assign current_backplane_bit_o = st.bp;

  always_comb begin
    next_st = st;
    if (cmd_in) begin
      // a new code always restarts the parameter count
      next_st.cmd = link.data;
      next_st.index = first_param_index_i;
      next_st.drop = update_busy_i;
      if (is_load_cmd(link.data)) begin
        next_st.state = CDI_PARAM;
      end else begin
        next_st.state = CDI_IDLE;
      end
    end else begin
      unique case (st.state)
        CDI_IDLE: begin
          next_st.state = CDI_IDLE;
        end
        CDI_PARAM: begin
          if (byte_in) begin
            if (accept && st.cmd == `CDI_CMD_LOAD_SEGMENTS) begin
              next_st.seg = place_byte(st.seg, st.index, stored_byte);
            end
            if (accept && st.cmd == `CDI_CMD_LOAD_BACKPLANE) begin
              next_st.bp = stored_byte[`CDI_BP_BIT];
            end
            next_st.index = st.index + 5'h01;
            // one byte for the backplane; no wrap past the last segment byte
            if (st.cmd == `CDI_CMD_LOAD_BACKPLANE || st.index == LAST_INDEX) begin
              next_st.state = CDI_IDLE;
            end
          end
        end
        default: begin
          next_st.state = CDI_IDLE;
        end
      endcase
    end
    // the finished update owns the image over a same-cycle parameter byte
    if (update_done_i) begin
      next_st.seg = next_segment_image_i;
      next_st.bp = next_backplane_bit_i;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
    // image fields left out on purpose: they outlive resets
    if (rst_i) begin
      st.state <= CDI_IDLE;
      st.cmd <= 8'h00;
      st.index <= 5'h00;
      st.drop <= 1'b0;
    end
  end
endmodule

// *** cdi_map.svh ***
`ifndef CDI_MAP_SVH
`define CDI_MAP_SVH
// command codes
`define CDI_CMD_LOAD_SEGMENTS 8'h01
`define CDI_CMD_LOAD_BACKPLANE 8'h02
// parameter field positions
`define CDI_BP_BIT 0
`define CDI_POL_INV_BIT 0
// image geometry
`define CDI_SEG_COUNT 256
`define CDI_SEG_BYTES 32
// host register offsets (byte addresses)
`define CDI_REG_CTRL 8'h00
`define CDI_REG_DATA 8'h04
`define CDI_REG_STATUS 8'h08
`define CDI_REG_RANGE 8'h0C
// control register fields
`define CDI_CTRL_GO_BIT 0
`define CDI_CTRL_CMD_LSB 8
// range register fields
`define CDI_RANGE_FIRST_LSB 0
`define CDI_RANGE_LAST_LSB 8
`define CDI_RANGE_RESET 32'h00001F00
`endif

// *** cdi_pkg.sv ***
package cdi_pkg;
  typedef enum logic [1:0] {CDI_IDLE, CDI_PARAM} cdi_dev_state_t;
  typedef enum logic [1:0] {CDI_H_IDLE, CDI_H_CMD, CDI_H_DATA, CDI_H_WAIT} cdi_host_state_t;
endpackage

// *** cdi_link_if.sv ***
`timescale 1ns/100ps
interface cdi_link_if;
  logic valid;
  logic is_cmd;
  logic [7:0] data;
  logic ready;
  modport host (output valid, output is_cmd, output data, input ready);
  modport dev (input valid, input is_cmd, input data, output ready);
endinterface

// *** cdi_host.sv ***
`timescale 1ns/100ps
`include "cdi_map.svh"
module cdi_host
  import cdi_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // update state of the device
  input wire logic update_busy_i,
  // command link
  cdi_link_if.host link
);
  typedef struct packed {
    cdi_host_state_t state;
    logic [7:0] cmd;
    logic [7:0] out;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] range;
  } cdi_hst_t;
  cdi_hst_t st;
  cdi_hst_t next_st;
  logic req;

  assign req = cyc_i && stb_i && !st.ack;
  assign ack_o = st.ack;
  assign dat_o = st.rdata;
  assign link.valid = (st.state == CDI_H_CMD) || (st.state == CDI_H_DATA);
  assign link.is_cmd = st.state == CDI_H_CMD;
  assign link.data = st.out;

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    // writes stall while a byte is still on the link
    if (req && (!we_i || st.state == CDI_H_IDLE)) begin
      next_st.ack = 1'b1;
      next_st.rdata = 32'h00000000;
      unique case (adr_i)
        `CDI_REG_CTRL: begin
          if (we_i && sel_i[1]) begin
            next_st.cmd = dat_i[`CDI_CTRL_CMD_LSB +: 8];
          end
          if (we_i && sel_i[0] && dat_i[`CDI_CTRL_GO_BIT]) begin
            // hold off during an update
            if (!update_busy_i) begin
              next_st.state = CDI_H_CMD;
              next_st.out = next_st.cmd;
            end
          end
          next_st.rdata[`CDI_CTRL_CMD_LSB +: 8] = st.cmd;
        end
        `CDI_REG_DATA: begin
          if (we_i && sel_i[0]) begin
            next_st.state = CDI_H_DATA;
            next_st.out = dat_i[7:0];
          end
        end
        `CDI_REG_STATUS: begin
          next_st.rdata[0] = st.state != CDI_H_IDLE;
          next_st.rdata[1] = update_busy_i;
        end
        `CDI_REG_RANGE: begin
          if (we_i && sel_i[1:0] == 2'h3) begin
            next_st.range = dat_i[15:0];
          end
          next_st.rdata[15:0] = st.range;
        end
        default: begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end
    if (link.valid && link.ready) begin
      next_st.state = CDI_H_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{state: CDI_H_IDLE, cmd: 8'h00, out: 8'h00, ack: 1'b0,
              rdata: 32'h00000000, range: 16'(`CDI_RANGE_RESET)};
    end else begin
      st <= next_st;
    end
  end
endmodule

// *** cdi_checker.sv ***
`timescale 1ns/100ps
`include "cdi_map.svh"
module cdi_checker #(
  parameter int SEG_COUNT = `CDI_SEG_COUNT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic valid,
  input wire logic is_cmd,
  input wire logic [7:0] data,
  input wire logic ready,
  // update context and stored image
  input wire logic busy_i,
  input wire logic done_i,
  input wire logic [SEG_COUNT-1:0] next_seg_i,
  input wire logic next_bp_i,
  input wire logic [SEG_COUNT-1:0] cur_seg_i,
  input wire logic cur_bp_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cmd;
    valid && is_cmd;
  endsequence
  sequence s_done;
    done_i;
  endsequence
  sequence s_busy;
    busy_i && !done_i;
  endsequence
  link_ready_a: assert property (ready) else $error("link not ready");
  one_beat_a: assert property (valid |=> !valid) else $error("byte held");
  cmd_code_a: assert property (s_cmd |-> data inside {8'h01, 8'h02}) else $error("bad code");
  cmd_gap_a: assert property (s_cmd |=> !valid [*2]) else $error("byte too soon");
  rst_idle_a: assert property ($fell(rst_i) |-> !valid) else $error("busy link");
  cmd_busy_a: assert property (s_cmd |-> !$past(busy_i))
    else $error("command sent during update");
  seg_copy_a: assert property (s_done |=> cur_seg_i == $past(next_seg_i))
    else $error("segment image not copied");
  bp_copy_a: assert property (s_done |=> cur_bp_i == $past(next_bp_i))
    else $error("backplane bit not copied");
  busy_hold_a: assert property (s_busy |=> $stable(cur_seg_i) && $stable(cur_bp_i))
    else $error("image changed during update");
endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, busy, done, nbp, bp;
  logic [7:0] adr;
  logic [31:0] dat, rdat, rd;
  logic [1:0] pol;
  logic [3:0] sel;
  logic [4:0] fi;
  logic [255:0] nseg, seg;
  int n_fail = 0;
  int checks = 0;
  cdi_link_if lnk();
  cdi_host cdi_host_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .update_busy_i(busy), .link(lnk.host));
  cdi_dev cdi_dev_i (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.dev),
    .polarity_mode_field_i(pol), .first_param_index_i(fi), .update_busy_i(busy),
    .update_done_i(done), .next_segment_image_i(nseg), .next_backplane_bit_i(nbp),
    .current_segment_image_o(seg), .current_backplane_bit_o(bp));
  cdi_checker cdi_checker_i (.clk_i(clk_i), .rst_i(rst_i), .valid(lnk.valid),
    .is_cmd(lnk.is_cmd), .data(lnk.data), .ready(lnk.ready), .busy_i(busy),
    .done_i(done), .next_seg_i(nseg), .next_bp_i(nbp), .cur_seg_i(seg), .cur_bp_i(bp));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // write stalls while the link is busy, so no fixed wait here
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic ld(input logic [7:0] c, input logic [7:0] b);
    wb(1'b1, 8'h00, {16'h0000, c, 8'h01});
    wb(1'b1, 8'h04, {24'h000000, b});
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_reg;
    wb(1'b0, 8'h0C, 32'h00000000);
    chk("range", rd, 32'h00001F00);
    wb(1'b1, 8'h0C, 32'h00000A05);
    wb(1'b0, 8'h0C, 32'h00000000);
    chk("range wr", rd, 32'h00000A05);
    wb(1'b0, 8'h10, 32'h00000000);
    chk("unmapped", rd, 32'h00000000);
    $display("test reg done");
  endtask
  task automatic t_pol;
    for (int p = 0; p < 4; p++) begin
      pol <= p[1:0];
      ld(8'h01, 8'hA5);
      chk("seg", seg[7:0], p[0] ? 8'h5A : 8'hA5);
      ld(8'h02, 8'hFE);
      chk("bp", bp, p[0]);
    end
    pol <= 2'h0;
    fi <= 5'h1F;
    ld(8'h01, 8'h3C);
    chk("top", seg[255:248], 8'h3C);
    $display("test polarity done");
  endtask
  task automatic t_busy;
    fi <= 5'h00;
    ld(8'h01, 8'h11);
    wb(1'b1, 8'h00, 32'h00000101);
    busy <= 1'b1;
    wb(1'b1, 8'h04, 32'h000000EE);
    repeat (3) @(posedge clk_i);
    chk("busy", seg[7:0], 8'h11);
    wb(1'b1, 8'h00, 32'h00000201);
    wb(1'b1, 8'h04, 32'h00000000);
    repeat (3) @(posedge clk_i);
    chk("busy bp", bp, 1'b1);
    chk("busy seg", seg[15:8], 8'h56);
    wb(1'b0, 8'h08, 32'h00000000);
    chk("status", rd, 32'h00000002);
    busy <= 1'b0;
    $display("test busy done");
  endtask
  task automatic t_done;
    nseg <= {8{32'h12345678}};
    nbp <= 1'b1;
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("seg", seg[31:0], 32'h12345678);
    chk("bp", bp, 1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("keep", seg[31:0], 32'h12345678);
    chk("keep bp", bp, 1'b1);
    wb(1'b0, 8'h00, 32'h00000000);
    chk("ctrl rst", rd, 32'h00000000);
    wb(1'b0, 8'h0C, 32'h00000000);
    chk("range rst", rd, 32'h00001F00);
    $display("test update done");
  endtask
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, busy, done, nbp} = '0;
    {adr, dat, pol, fi, nseg, sel} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reg;
    t_pol;
    t_done;
    t_busy;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    summarize;
  end
endmodule
